// >>> dss_pkg.sv
// shared constants and types for the diagnosis / sense-select block
package dss_pkg;
  localparam int NUM_CH = 4;
  localparam int SEL_W = 3;
  localparam int CNT_W = 3;

  // register byte offsets
  localparam logic [7:0] OFS_DIAG_CTRL = 8'h00;
  localparam logic [7:0] OFS_HW_CFG = 8'h04;
  localparam logic [7:0] OFS_PAR_SLEW = 8'h08;
  localparam logic [7:0] OFS_RESTART_CNT = 8'h0c;
  localparam logic [7:0] OFS_WARN_DIAG = 8'h10;
  localparam logic [7:0] OFS_STD_DIAG = 8'h14;

  // field positions
  localparam int DCR_SEL_LSB = 0;
  localparam int DCR_EN_LSB = 4;
  localparam int HW_CONFIG_REGISTER_CLR_BIT = 0;
  localparam int PCS_CNTCLR_BIT = 0;
  localparam int PCS_SLEW_BIT = 1;
  localparam int PCS_SLEWSTATE_LSB = 8;
  localparam int STD_BYPASS_BIT = 0;
  localparam int STD_LATCH_LSB = 4;

  // sense select codes
  localparam logic [SEL_W-1:0] SEL_VERIFY = 3'h5;
  localparam logic [SEL_W-1:0] SEL_OFF_A = 3'h6;
  localparam logic [SEL_W-1:0] SEL_OFF_B = 3'h7;

  // reset values
  localparam logic [SEL_W-1:0] SEL_RST = 3'h6;
  localparam logic [NUM_CH-1:0] EN_RST = 4'h0;
  localparam logic [NUM_CH-1:0] SLEW_RST = 4'h0;

  typedef struct packed {
    logic [NUM_CH-1:0] overTemp;
    logic [NUM_CH-1:0] overload;
    logic [NUM_CH-1:0] chanOn;
    logic [NUM_CH-1:0] vdsLow;
    logic [NUM_CH-1:0] hardFail;
    logic [NUM_CH-1:0] restartReq;
  } dss_chan_s;

  typedef struct packed {
    logic senseOe;
    logic senseVerify;
    logic [1:0] senseChan;
  } dss_sense_s;
endpackage

// >>> dss_diag_sense.sv
// diagnosis flags, sense multiplexer and selected-channel commands
// What this block does
// RL1 - each warning bit reads as that channel's overtemperature OR its latched overload flag.
// RL2 - overload events latch per channel and clear on each warning word transmission unless the channel is at its restart limit and shut off.
// RL3 - protection latches are released only by the host's latch-clear command.
// RL4 - the proportional sense drives only while the channel is on, below bypass threshold, diagnosis-enabled and fault-free.
// RL5 - a hard failure on the selected channel keeps or puts the sense output in high impedance.
// RL6 - the select field routes the chosen channel to the sense output and codes 110 and 111 disable it.
// RL7 - select code 101 drives the fixed verification current regardless of channel state.
// RL8 - writing one to the counter-clear bit clears the selected channel's restart counter and latches it off.
// RL9 - writing one to the slew-change bit changes the selected channel's slew setting.
// RL10 - reading the restart count returns the selected channel's internal counter.
// RL11 - the bypass monitor bit reports the selected channel's drain-source comparison.
// RL12 - the host waits turn-on time plus settling time before sampling the sense output.
// RL13 - the select field is three bits and other codes pick one of the four channels.
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module dss_diag_sense
  import dss_pkg::*;
#(
  parameter logic [CNT_W-1:0] RESTART_MAX = 3'h7
) (
  // system
  input wire logic mclk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link side: warning word sent
  input wire logic lnkClk,
  input wire logic warnSentStb,
  // channel status from power stage
  input wire dss_chan_s chanIn,
  // outputs to power stage and sense path
  output dss_sense_s sense,
  output logic [NUM_CH-1:0] chanLatchedOff,
  output logic [NUM_CH-1:0] slewSel
);

  // pick a channel bit by the low select bits
  function automatic logic chanBit(input logic [NUM_CH-1:0] v, input logic [SEL_W-1:0] s);
    chanBit = v[s[1:0]];
  endfunction

  // link domain: event turned into a toggle, reset synced locally
  logic lnkRst1Reg, lnkRst2Reg, lnkTogReg, lnkTogNext;
  always_comb begin
    lnkTogNext = lnkTogReg ^ warnSentStb;
  end
  always_ff @(posedge lnkClk) begin
    lnkRst1Reg <= rst_n;
    lnkRst2Reg <= lnkRst1Reg;
    if (!lnkRst2Reg) begin
      lnkTogReg <= 1'b0;
    end else begin
      lnkTogReg <= lnkTogNext;
    end
  end

  // main domain synchronisers
  dss_chan_s chanS1Reg, chanS2Reg;
  logic [NUM_CH-1:0] restartDlyReg;
  logic tog1Reg, tog2Reg, tog3Reg;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chanS1Reg <= '0;
      chanS2Reg <= '0;
      restartDlyReg <= '0;
      tog1Reg <= 1'b0;
      tog2Reg <= 1'b0;
      tog3Reg <= 1'b0;
    end else begin
      chanS1Reg <= chanIn;
      chanS2Reg <= chanS1Reg;
      restartDlyReg <= chanS2Reg.restartReq;
      tog1Reg <= lnkTogReg;
      tog2Reg <= tog1Reg;
      tog3Reg <= tog2Reg;
    end
  end

  logic warnSent;
  logic [NUM_CH-1:0] restartEv;
  assign warnSent = tog2Reg ^ tog3Reg;
  assign restartEv = chanS2Reg.restartReq & ~restartDlyReg;

  // register state
  logic [SEL_W-1:0] selReg, selNext;
  logic [NUM_CH-1:0] diagEnReg, diagEnNext;
  logic [NUM_CH-1:0] slewReg, slewNext;
  logic [NUM_CH-1:0] warnReg, warnNext;
  logic [NUM_CH-1:0] latchReg, latchNext;
  logic [CNT_W-1:0] cntReg [NUM_CH];
  logic [CNT_W-1:0] cntNext [NUM_CH];
  logic ackReg, ackNext;
  logic [31:0] datReg, datNext;
  dss_sense_s senseReg, senseNext;

  // decoded bus strobes and selected-channel helpers
  logic req, wr, rd;
  logic wrDiagCtrl, wrHwCfg, wrParSlew;
  logic cntClrCmd, slewCmd, latchClrCmd;
  logic [NUM_CH-1:0] atMax, warnWord, fault, selOneHot;
  logic isChan, bypass;
  logic [1:0] selIdx;

  // a second request is not taken while ack is still up
  assign req = wb_cyc_i & wb_stb_i & ~ackReg;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign wrDiagCtrl = wr && (wb_adr_i == OFS_DIAG_CTRL);
  assign wrHwCfg = wr && (wb_adr_i == OFS_HW_CFG);
  assign wrParSlew = wr && (wb_adr_i == OFS_PAR_SLEW);

  assign selIdx = selReg[1:0];
  assign isChan = (selReg != SEL_VERIFY) && (selReg != SEL_OFF_A) && (selReg != SEL_OFF_B); // RL13
  assign selOneHot = isChan ? (NUM_CH'(1) << selIdx) : '0;

  // counter-clear and slew commands on non-channel codes are ignored; latch clear is not
  assign cntClrCmd = wrParSlew && wb_dat_i[PCS_CNTCLR_BIT] && isChan;
  assign slewCmd = wrParSlew && wb_dat_i[PCS_SLEW_BIT] && isChan;
  assign latchClrCmd = wrHwCfg && wb_dat_i[HW_CONFIG_REGISTER_CLR_BIT];

  assign warnWord = warnReg | chanS2Reg.overTemp; // RL1
  assign fault = chanS2Reg.overTemp | chanS2Reg.hardFail | latchReg;
  // comparator reads high while vds sits above threshold
  assign bypass = isChan & ~chanBit(chanS2Reg.vdsLow, selReg); // RL11

  // restart counters saturate at the limit
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      atMax[i] = (cntReg[i] == RESTART_MAX);
      cntNext[i] = cntReg[i];
      if (restartEv[i] && !atMax[i]) begin
        cntNext[i] = cntReg[i] + 1'b1;
      end
    end
    if (cntClrCmd) begin
      cntNext[selIdx] = '0; // RL8
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cntReg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        cntReg[i] <= cntNext[i];
      end
    end
  end

  // protection latches
  always_comb begin
    // reaching the restart limit shuts the channel off
    latchNext = latchReg | atMax;
    if (cntClrCmd) begin
      latchNext = latchNext | selOneHot; // RL8
    end
    // clear wins for one cycle; a channel still at its limit latches again
    if (latchClrCmd) begin
      latchNext = '0; // RL3
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      latchReg <= '0;
    end else begin
      latchReg <= latchNext;
    end
  end

  // warning flags
  always_comb begin
    warnNext = warnReg;
    // clear spares channels that are self-protected
    if (warnSent) begin
      warnNext = warnReg & (atMax & latchReg); // RL2
    end
    // a new overload in the clear cycle wins
    warnNext = warnNext | chanS2Reg.overload; // RL2
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      warnReg <= '0;
    end else begin
      warnReg <= warnNext;
    end
  end

  // configuration fields
  always_comb begin
    selNext = selReg;
    diagEnNext = diagEnReg;
    slewNext = slewReg;
    if (wrDiagCtrl) begin
      selNext = wb_dat_i[DCR_SEL_LSB +: SEL_W];
      diagEnNext = wb_dat_i[DCR_EN_LSB +: NUM_CH];
    end
    if (slewCmd) begin
      slewNext = slewReg ^ selOneHot; // RL9
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      selReg <= SEL_RST;
      diagEnReg <= EN_RST;
      slewReg <= SLEW_RST;
    end else begin
      selReg <= selNext;
      diagEnReg <= diagEnNext;
      slewReg <= slewNext;
    end
  end

  // bus answer: ack and read data one cycle after the request is taken
  always_comb begin
    ackNext = req;
    datNext = '0;
    if (rd) begin
      case (wb_adr_i)
        OFS_DIAG_CTRL: begin
          datNext[DCR_SEL_LSB +: SEL_W] = selReg;
          datNext[DCR_EN_LSB +: NUM_CH] = diagEnReg;
        end
        OFS_PAR_SLEW: datNext[PCS_SLEWSTATE_LSB +: NUM_CH] = slewReg;
        OFS_RESTART_CNT: datNext[CNT_W-1:0] = isChan ? cntReg[selIdx] : '0; // RL10
        OFS_WARN_DIAG: datNext[NUM_CH-1:0] = warnWord; // RL1
        OFS_STD_DIAG: begin
          datNext[STD_BYPASS_BIT] = bypass; // RL11
          datNext[STD_LATCH_LSB +: NUM_CH] = latchReg;
        end
        default: datNext = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ackReg <= 1'b0;
      datReg <= '0;
    end else begin
      ackReg <= ackNext;
      datReg <= datNext;
    end
  end

  // sense path
  always_comb begin
    senseNext.senseChan = selIdx; // RL6
    senseNext.senseVerify = (selReg == SEL_VERIFY); // RL7
    senseNext.senseOe = (selReg == SEL_VERIFY) // RL7
      | (isChan // RL6
         & chanBit(chanS2Reg.chanOn, selReg) & chanBit(chanS2Reg.vdsLow, selReg) // RL4
         & chanBit(diagEnReg, selReg) & ~chanBit(fault, selReg) // RL4
         & ~chanBit(chanS2Reg.hardFail, selReg)); // RL5
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      senseReg <= '0;
    end else begin
      senseReg <= senseNext;
    end
  end

  // host must still allow turn-on plus settling before sampling the sense pin (RL12)
  assign wb_ack_o = ackReg;
  assign wb_dat_o = datReg;
  assign sense = senseReg;
  assign chanLatchedOff = latchReg;
  assign slewSel = slewReg;

endmodule // dss_diag_sense

// >>> dss_diag_sense_sva.sv
// concurrent checks on bus handshake, sense path and command effects
`timescale 1ns/1ps
module dss_diag_sense_sva
  import dss_pkg::*;
#(parameter logic [CNT_W-1:0] RESTART_MAX = 3'h7) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // power stage and sense
  input wire dss_chan_s chanIn,
  input wire dss_sense_s sense,
  input wire logic [NUM_CH-1:0] chanLatchedOff,
  input wire logic [NUM_CH-1:0] slewSel
);
  wire logic wrReq = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h14)
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_latch_release: assert property (|($past(chanLatchedOff) & ~chanLatchedOff) |->
    wb_ack_o && $past(wrReq && wb_adr_i == OFS_HW_CFG && wb_dat_i[0]))
    else $error("latch released without clear command");
  a_slew_cmd: assert property ($changed(slewSel) |->
    wb_ack_o && $past(wrReq && wb_adr_i == OFS_PAR_SLEW && wb_dat_i[1]))
    else $error("slew changed without command");
  // three cycles: two sync flops and the output register
  a_sense_cond: assert property (sense.senseOe && !sense.senseVerify |-> $past(
    chanIn.chanOn[sense.senseChan] && chanIn.vdsLow[sense.senseChan]
    && !chanIn.overTemp[sense.senseChan], 3)) else $error("sense driven off-condition");
  a_sense_hardfail: assert property (sense.senseOe && !sense.senseVerify |->
    !$past(chanIn.hardFail[sense.senseChan], 3)) else $error("sense driven on hard fail");
  a_warn_overtemp: assert property (wb_ack_o && $past(!wb_we_i &&
    wb_adr_i == OFS_WARN_DIAG) |-> &(wb_dat_o[3:0] | ~$past(chanIn.overTemp, 3)))
    else $error("warning bit missing overtemperature");
endmodule // dss_diag_sense_sva
bind dss_diag_sense dss_diag_sense_sva #(.RESTART_MAX(RESTART_MAX)) dss_diag_sense_sva_inst (
  .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .chanIn(chanIn), .sense(sense), .chanLatchedOff(chanLatchedOff),
  .slewSel(slewSel));

// >>> dss_link_model.sv
// link-side partner sending bursts of link clock with the warning-sent strobe
`timescale 1ns/1ps
module dss_link_model (
  // link pins
  output logic lnkClk,
  output logic warnSentStb
);
  initial begin
    lnkClk = 1'b0;
    warnSentStb = 1'b0;
  end
  // clock stands still between frames, so the reset sync needs its own burst
  task automatic send(input logic withStb);
    #2;
    for (int i = 0; i < 5; i++) begin
      warnSentStb = withStb && (i == 3);
      #15 lnkClk = 1'b1;
      #15 lnkClk = 1'b0;
    end
    warnSentStb = 1'b0;
  endtask
endmodule // dss_link_model

// >>> tb_dss_diag_sense.sv
// register-level bench for the diagnosis and sense-select block
`timescale 1ns/1ps
module tb_dss_diag_sense
  import dss_pkg::*;
;
  logic mclk, rst_n, req, wbWe, wbAck, lnkClk, warnSentStb;
  logic [7:0] wbAdr;
  logic [31:0] wbDat, wbRdat;
  logic [3:0] latched, slewSel;
  dss_chan_s chanIn;
  dss_sense_s sense;
  int errors, num_checks, cycles;
  dss_diag_sense dss_diag_sense_inst (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat),
    .wb_dat_o(wbRdat), .wb_ack_o(wbAck), .lnkClk(lnkClk), .warnSentStb(warnSentStb),
    .chanIn(chanIn), .sense(sense), .chanLatchedOff(latched), .slewSel(slewSel));
  dss_link_model dss_link_model_inst (.lnkClk(lnkClk), .warnSentStb(warnSentStb));
  always #5 mclk = ~mclk;
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    {req, wbWe, wbAdr, wbDat} <= {1'b1, we, a, d};
    do @(posedge mclk); while (wbAck !== 1'b1);
    q = wbRdat;
    req <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // sync plus output register, with margin
  task automatic settle();
    repeat (5) @(posedge mclk);
  endtask
  task automatic restarts(input int ch, input int n);
    repeat (n) begin
      chanIn.restartReq[ch] <= 1'b1;
      settle();
      chanIn.restartReq[ch] <= 1'b0;
      settle();
    end
  endtask
  initial begin
    {mclk, rst_n, req, wbWe, wbAdr, wbDat} = '0;
    chanIn = '0;
    fork
      dss_link_model_inst.send(1'b0);
      repeat (10) @(posedge mclk);
    join
    rst_n <= 1'b1;
    rd(OFS_DIAG_CTRL, 32'h6);
    chanIn.chanOn <= 4'hf;
    chanIn.vdsLow <= 4'hf;
    for (int c = 0; c < 8; c++) begin
      wr(OFS_DIAG_CTRL, 32'hf0 | c);
      settle();
      if (c < 5) chk({28'h0, sense}, 32'h8 | (c & 3));
      chk({31'h0, sense.senseVerify}, c == 5);
      if (c > 5) chk({31'h0, sense.senseOe}, 32'h0);
    end
    $display("select test done");
    wr(OFS_DIAG_CTRL, 32'hf2);
    chanIn.hardFail[2] <= 1'b1;
    settle();
    chk({31'h0, sense.senseOe}, 32'h0);
    chanIn.hardFail[2] <= 1'b0;
    chanIn.vdsLow[2] <= 1'b0;
    settle();
    chk({31'h0, sense.senseOe}, 32'h0);
    rd(OFS_STD_DIAG, 32'h1);
    chanIn.vdsLow[2] <= 1'b1;
    $display("fault test done");
    wr(OFS_DIAG_CTRL, 32'hf1);
    wr(OFS_PAR_SLEW, 32'h2);
    chk({28'h0, slewSel}, 32'h2);
    rd(OFS_PAR_SLEW, 32'h200);
    restarts(1, 3);
    rd(OFS_RESTART_CNT, 32'h3);
    wr(OFS_PAR_SLEW, 32'h1);
    chk({28'h0, latched}, 32'h2);
    rd(OFS_RESTART_CNT, 32'h0);
    wr(OFS_HW_CFG, 32'h1);
    chk({28'h0, latched}, 32'h0);
    $display("command test done");
    chanIn.overload[3] <= 1'b1;
    settle();
    chanIn.overload[3] <= 1'b0;
    settle();
    rd(OFS_WARN_DIAG, 32'h8);
    chanIn.overTemp[0] <= 1'b1;
    settle();
    rd(OFS_WARN_DIAG, 32'h9);
    dss_link_model_inst.send(1'b1);
    settle();
    rd(OFS_WARN_DIAG, 32'h1);
    restarts(3, 7);
    chanIn.overload[3] <= 1'b1;
    settle();
    chanIn.overload[3] <= 1'b0;
    dss_link_model_inst.send(1'b1);
    settle();
    rd(OFS_WARN_DIAG, 32'h9);
    $display("warning test done");
    rd(8'h20, 32'h0);
    $display("unmapped test done");
    report_and_stop();
  end
endmodule // tb_dss_diag_sense
